//--- rtl/plc_protection_limit_config.sv
// Protection limit configuration register with decoded limit outputs.
`timescale 1ns/100ps
module plc_protection_limit_config
    import plc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic [PLC_ADDR_W-1:0] i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [PLC_DATA_W-1:0] i_reg_wdata,
    output logic      [PLC_DATA_W-1:0] o_reg_rdata,
    output logic                       o_reg_ack,
    output logic                       o_reg_hit,
    output logic                       o_overtemp_cap_en,
    output logic      [PLC_MA_W-1:0]   o_overtemp_cap_ma,
    output logic                       o_closed_loop_stall_check_en,
    output logic                       o_open_loop_stall_check_en,
    output logic                       o_missing_motor_check_en,
    output logic                       o_torque_constant_check_en,
    output logic                       o_speed_anomaly_check_en,
    output logic                       o_current_limit_lock_check_en,
    output logic                       o_accel_limit_en,
    output logic      [PLC_MA_W-1:0]   o_accel_limit_ma,
    output logic      [PLC_MA_W-1:0]   o_lock_limit_ma
);

    // ==========================================================
    // Register access decode.
    logic [PLC_DATA_W-1:0] cfg_q;
    logic [PLC_DATA_W-1:0] cfg_d;
    logic                  addr_hit;
    logic                  wr_hit;
    logic                  access;

    assign addr_hit = (i_reg_addr == PLC_ADDR_PROT_LIMIT_CONFIG);
    assign wr_hit   = i_reg_wr && addr_hit;
    assign access   = i_reg_wr || i_reg_rd;
    assign cfg_d    = wr_hit ? i_reg_wdata : cfg_q; // R01

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= PLC_RESET_PROT_LIMIT_CONFIG; // R01
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // A read returns the contents held before any write in the same cycle.
    // Unmapped addresses read as zero and leave the register untouched.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
            o_reg_ack   <= 1'b0;
            o_reg_hit   <= 1'b0;
        end else begin
            o_reg_rdata <= (i_reg_rd && addr_hit) ? cfg_q : 16'h0000; // R01
            o_reg_ack   <= access;
            o_reg_hit   <= access && addr_hit;
        end
    end

    // ==========================================================
    // Field decode from the next register value, so the decoded outputs
    // change on the same edge that stores the write.
    logic [1:0]          ot_sel_d;
    logic [3:0]          accel_code_d;
    logic [PLC_MA_W-1:0] ot_cap_ma_d;
    logic [PLC_MA_W-1:0] accel_ma_d;
    logic [PLC_MA_W-1:0] lock_ma_d;

    assign ot_sel_d     = cfg_d[PLC_OT_CAP_MSB:PLC_OT_CAP_LSB];
    assign accel_code_d = cfg_d[PLC_ACCEL_MSB:PLC_ACCEL_LSB];
    assign accel_ma_d   = PLC_MA_W'(PLC_MA_W'(accel_code_d)
                                    * PLC_ACCEL_STEP_MA); // R09

    always_comb begin
        case (ot_sel_d)
            2'h1:    ot_cap_ma_d = PLC_OT_CAP_1_MA; // R02
            2'h2:    ot_cap_ma_d = PLC_OT_CAP_2_MA;
            2'h3:    ot_cap_ma_d = PLC_OT_CAP_3_MA;
            default: ot_cap_ma_d = 12'h000;
        endcase
    end

    plc_lock_limit_decode u_lock_decode (
        .i_code      (cfg_d[PLC_LOCK_CODE_MSB:PLC_LOCK_CODE_LSB]),
        .i_range_sel (cfg_d[PLC_RANGE_SEL_BIT]),
        .o_limit_ma  (lock_ma_d)
    );

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_overtemp_cap_en             <= 1'b0;
            o_overtemp_cap_ma             <= 12'h000;
            o_closed_loop_stall_check_en  <= 1'b0;
            o_open_loop_stall_check_en    <= 1'b0;
            o_missing_motor_check_en      <= 1'b0;
            o_torque_constant_check_en    <= 1'b0;
            o_speed_anomaly_check_en      <= 1'b0;
            o_current_limit_lock_check_en <= 1'b0;
            o_accel_limit_en              <= 1'b0;
            o_accel_limit_ma              <= 12'h000;
            o_lock_limit_ma               <= PLC_LOCK_R0_0_MA;
        end else begin
            o_overtemp_cap_en             <= (ot_sel_d != 2'h0); // R02
            o_overtemp_cap_ma             <= ot_cap_ma_d; // R13
            o_closed_loop_stall_check_en  <=
                cfg_d[PLC_CLOSED_STALL_BIT]; // R03
            o_open_loop_stall_check_en    <= cfg_d[PLC_OPEN_STALL_BIT]; // R04
            o_missing_motor_check_en      <= cfg_d[PLC_MISSING_BIT]; // R05
            o_torque_constant_check_en    <= cfg_d[PLC_TORQUE_BIT]; // R06
            o_speed_anomaly_check_en      <= cfg_d[PLC_SPEED_BIT]; // R07
            o_current_limit_lock_check_en <= cfg_d[PLC_CURR_LOCK_BIT]; // R08
            o_accel_limit_en              <= (accel_code_d != 4'h0); // R09
            o_accel_limit_ma              <= accel_ma_d;
            o_lock_limit_ma               <= lock_ma_d; // R12
        end
    end

    // ==========================================================
    // Assertions.
    sequence s_cfg_write;
        i_reg_wr && addr_hit;
    endsequence

    property p_write_stores;
        @(posedge i_clk) disable iff (i_rst)
        s_cfg_write |=> (cfg_q == $past(i_reg_wdata));
    endproperty
    a_write_stores: assert property (p_write_stores) // R01
        else $error("Register write was not stored.");

    property p_read_back;
        @(posedge i_clk) disable iff (i_rst)
        (i_reg_rd && addr_hit) |=> (o_reg_ack && o_reg_hit
                                    && o_reg_rdata == $past(cfg_q));
    endproperty
    a_read_back: assert property (p_read_back) // R01
        else $error("Read did not return the register contents.");

    property p_ot_cap;
        @(posedge i_clk) disable iff (i_rst)
        o_overtemp_cap_ma == ((cfg_q[15:14] == 2'h1) ? 12'h3e8 :
                              (cfg_q[15:14] == 2'h2) ? 12'h640 :
                              (cfg_q[15:14] == 2'h3) ? 12'h7d0 : 12'h000)
        && o_overtemp_cap_en == (cfg_q[15:14] != 2'h0);
    endproperty
    a_ot_cap: assert property (p_ot_cap) // R02
        else $error("Over-temperature cap does not match its field.");

    property p_check_enables;
        @(posedge i_clk) disable iff (i_rst)
        {o_closed_loop_stall_check_en, o_open_loop_stall_check_en,
         o_missing_motor_check_en, o_torque_constant_check_en,
         o_speed_anomaly_check_en, o_current_limit_lock_check_en}
            == cfg_q[13:8];
    endproperty
    a_check_enables: assert property (p_check_enables) // R03
        else $error("Lock check enables do not match the register.");

    property p_closed_stall_follows;
        @(posedge i_clk) disable iff (i_rst)
        (s_cfg_write ##0 i_reg_wdata[13]) |=> o_closed_loop_stall_check_en;
    endproperty
    a_closed_stall_follows: assert property (p_closed_stall_follows) // R03
        else $error("Closed-loop stall check not enabled by write.");

    property p_open_stall_off;
        @(posedge i_clk) disable iff (i_rst)
        (s_cfg_write ##0 !i_reg_wdata[12]) |=> !o_open_loop_stall_check_en;
    endproperty
    a_open_stall_off: assert property (p_open_stall_off) // R04
        else $error("Open-loop stall check not disabled by write.");

    property p_accel_limit;
        @(posedge i_clk) disable iff (i_rst)
        o_accel_limit_ma == 12'(cfg_q[7:4] * 12'h0c8)
        && o_accel_limit_en == (cfg_q[7:4] != 4'h0);
    endproperty
    a_accel_limit: assert property (p_accel_limit) // R09
        else $error("Acceleration limit does not match its code.");

    property p_lock_range0;
        @(posedge i_clk) disable iff (i_rst)
        !cfg_q[0] |-> o_lock_limit_ma == ((cfg_q[2:1] == 2'h0) ? 12'h9c4 :
                                          (cfg_q[2:1] == 2'h1) ? 12'h76c :
                                          (cfg_q[2:1] == 2'h2) ? 12'h5dc :
                                                                 12'h384);
    endproperty
    a_lock_range0: assert property (p_lock_range0) // R10
        else $error("Lock limit range 0 decode is wrong.");

    property p_lock_range1;
        @(posedge i_clk) disable iff (i_rst)
        cfg_q[0] |-> o_lock_limit_ma == 12'((cfg_q[3:1] + 12'h001) * 12'h190);
    endproperty
    a_lock_range1: assert property (p_lock_range1) // R11
        else $error("Lock limit range 1 decode is wrong.");

    property p_range_switch;
        @(posedge i_clk) disable iff (i_rst)
        (s_cfg_write ##0 (i_reg_wdata[3:0] == 4'h9)) |=>
            (o_lock_limit_ma == 12'h7d0);
    endproperty
    a_range_switch: assert property (p_range_switch) // R12
        else $error("Range select did not switch the lock limit.");

    property p_unmapped_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && !addr_hit) |=> $stable(cfg_q) ##0 !o_reg_hit;
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // R13
        else $error("Unmapped write changed the register.");

endmodule

//--- rtl/plc_pkg.sv
// Constants for the protection limit configuration register.
// Notes on behaviour
// R01 - 16-bit register at address 0x94, resets to zero, all bits read/write.
// R02 - Bits 15:14 pick over-temperature cap: off, 1 A, 1.6 A, 2 A.
// R03 - Bit 13 enables the closed-loop stall check.
// R04 - Bit 12 enables the open-loop start-up stall check.
// R05 - Bit 11 enables the missing motor check.
// R06 - Bit 10 enables the abnormal torque constant check.
// R07 - Bit 9 enables the abnormal speed check.
// R08 - Bit 8 enables the lock check on lock current limit hit.
// R09 - Bits 7:4 give acceleration limit n times 0.2 A, zero disables.
// R10 - Range 0: bit 3 ignored, bits 2:1 give 2.5, 1.9, 1.5, 0.9 A.
// R11 - Range 1: bits 3:1 give 0.4 A plus 0.4 A per code step.
// R12 - Bit 0 selects range 0 or range 1 for the lock limit.
// R13 - Decoded settings follow the stored contents from the storing write on.
package plc_pkg;

    localparam int          PLC_DATA_W = 16;
    localparam int          PLC_ADDR_W = 8;
    localparam int          PLC_MA_W   = 12;

    // ==========================================================
    // Register map and reset value.
    localparam logic [7:0]  PLC_ADDR_PROT_LIMIT_CONFIG  = 8'h94;
    localparam logic [15:0] PLC_RESET_PROT_LIMIT_CONFIG = 16'h0000;

    // ==========================================================
    // Field positions.
    localparam int PLC_OT_CAP_MSB       = 15;
    localparam int PLC_OT_CAP_LSB       = 14;
    localparam int PLC_CLOSED_STALL_BIT = 13;
    localparam int PLC_OPEN_STALL_BIT   = 12;
    localparam int PLC_MISSING_BIT      = 11;
    localparam int PLC_TORQUE_BIT       = 10;
    localparam int PLC_SPEED_BIT        = 9;
    localparam int PLC_CURR_LOCK_BIT    = 8;
    localparam int PLC_ACCEL_MSB        = 7;
    localparam int PLC_ACCEL_LSB        = 4;
    localparam int PLC_LOCK_CODE_MSB    = 3;
    localparam int PLC_LOCK_CODE_LSB    = 1;
    localparam int PLC_RANGE_SEL_BIT    = 0;

    // ==========================================================
    // Current values in milliamperes.
    localparam logic [11:0] PLC_OT_CAP_1_MA       = 12'h3e8; // 1.0 A
    localparam logic [11:0] PLC_OT_CAP_2_MA       = 12'h640; // 1.6 A
    localparam logic [11:0] PLC_OT_CAP_3_MA       = 12'h7d0; // 2.0 A
    localparam logic [11:0] PLC_ACCEL_STEP_MA     = 12'h0c8; // 0.2 A
    localparam logic [11:0] PLC_LOCK_R0_0_MA      = 12'h9c4; // 2.5 A
    localparam logic [11:0] PLC_LOCK_R0_1_MA      = 12'h76c; // 1.9 A
    localparam logic [11:0] PLC_LOCK_R0_2_MA      = 12'h5dc; // 1.5 A
    localparam logic [11:0] PLC_LOCK_R0_3_MA      = 12'h384; // 0.9 A
    localparam logic [11:0] PLC_LOCK_R1_STEP_MA   = 12'h190; // 0.4 A

endpackage

//--- rtl/plc_lock_limit_decode.sv
// Lock-detect current limit decoder for both value ranges.
`timescale 1ns/100ps
module plc_lock_limit_decode
    import plc_pkg::*;
(
    input  wire logic [2:0]          i_code,
    input  wire logic                i_range_sel,
    output logic      [PLC_MA_W-1:0] o_limit_ma
);

    logic [PLC_MA_W-1:0] range0_ma;
    logic [PLC_MA_W-1:0] range1_ma;

    // The upper code bit plays no part in range 0.
    always_comb begin
        case (i_code[1:0])
            2'h0:    range0_ma = PLC_LOCK_R0_0_MA; // R10
            2'h1:    range0_ma = PLC_LOCK_R0_1_MA;
            2'h2:    range0_ma = PLC_LOCK_R0_2_MA;
            2'h3:    range0_ma = PLC_LOCK_R0_3_MA;
            default: range0_ma = PLC_LOCK_R0_0_MA;
        endcase
    end

    assign range1_ma  = PLC_MA_W'((PLC_MA_W'(i_code) + 12'h001)
                                  * PLC_LOCK_R1_STEP_MA); // R11
    assign o_limit_ma = i_range_sel ? range1_ma : range0_ma; // R12

endmodule

//--- verif/plc_host_model.sv
// Register host model that issues single-word accesses to the block.
`timescale 1ns/100ps
module plc_host_model
    import plc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_ack,
    input  wire logic                  i_hit,
    input  wire logic [PLC_DATA_W-1:0] i_rdata,
    output logic      [PLC_ADDR_W-1:0] o_addr,
    output logic                       o_wr,
    output logic                       o_rd,
    output logic      [PLC_DATA_W-1:0] o_wdata
);
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end

    // ==========================================================
    // One strobe cycle, answer sampled a cycle later.
    task automatic access(input logic wr, input logic rd,
                          input logic [7:0] addr, input logic [15:0] data,
                          output logic ack, output logic hit,
                          output logic [15:0] rdata);
        @(negedge i_clk);
        o_addr  = addr;
        o_wdata = data;
        o_wr    = wr;
        o_rd    = rd;
        @(negedge i_clk);
        ack     = i_ack;
        hit     = i_hit;
        rdata   = i_rdata;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        // Released lines flip so a stale value is never mistaken for data.
        o_addr  = ~addr;
        o_wdata = ~data;
    endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the protection limit configuration register.
`timescale 1ns/100ps
module testbench
    import plc_pkg::*;
;
    logic i_clk = 1'b0, i_rst = 1'b1, wr, rd, ack, hit, ot_en, ac_en;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, got, mdl_q, d;
    logic [11:0] ot_ma, ac_ma, lk_ma;
    logic [5:0] lock_en;
    logic a, h;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    int ot_tab[4] = '{0, 1000, 1600, 2000};
    int lk_tab[4] = '{2500, 1900, 1500, 900};

    always #5 i_clk = ~i_clk;

    plc_protection_limit_config dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
        .o_reg_hit(hit), .o_overtemp_cap_en(ot_en),
        .o_overtemp_cap_ma(ot_ma),
        .o_closed_loop_stall_check_en(lock_en[5]),
        .o_open_loop_stall_check_en(lock_en[4]),
        .o_missing_motor_check_en(lock_en[3]),
        .o_torque_constant_check_en(lock_en[2]),
        .o_speed_anomaly_check_en(lock_en[1]),
        .o_current_limit_lock_check_en(lock_en[0]),
        .o_accel_limit_en(ac_en), .o_accel_limit_ma(ac_ma),
        .o_lock_limit_ma(lk_ma));

    plc_host_model host (.i_clk(i_clk), .i_ack(ack), .i_hit(hit),
        .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata));

    // ==========================================================
    // Comparison and model checks.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic check_all();
        int lk;
        lk = mdl_q[0] ? (mdl_q[3:1] + 1) * 400 : lk_tab[mdl_q[2:1]];
        chk(16'(ot_en), 16'(mdl_q[15:14] != 2'h0));
        chk(16'(ot_ma), 16'(ot_tab[mdl_q[15:14]]));
        chk(16'(lock_en), 16'(mdl_q[13:8]));
        chk(16'(ac_en), 16'(mdl_q[7:4] != 4'h0));
        chk(16'(ac_ma), 16'(mdl_q[7:4] * 200));
        chk(16'(lk_ma), 16'(lk));
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [15:0] v);
        host.access(1'b1, 1'b0, ad, v, a, h, got);
        if (ad == PLC_ADDR_PROT_LIMIT_CONFIG) mdl_q = v;
        chk(16'({a, h}), 16'({1'b1, ad == PLC_ADDR_PROT_LIMIT_CONFIG}));
        check_all();
    endtask

    task automatic rd_reg(input logic [7:0] ad);
        host.access(1'b0, 1'b1, ad, 16'h0000, a, h, got);
        chk(got, (ad == PLC_ADDR_PROT_LIMIT_CONFIG) ? mdl_q : 16'h0000);
        chk(16'({a, h}), 16'({1'b1, ad == PLC_ADDR_PROT_LIMIT_CONFIG}));
    endtask

    task automatic do_reset();
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        mdl_q = PLC_RESET_PROT_LIMIT_CONFIG;
        check_all();
    endtask

    task automatic give_verdict();
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The ceiling leaves ample margin over the roughly 300 cycles used.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        void'($urandom(32'h0acb41e3));
        do_reset();
        rd_reg(PLC_ADDR_PROT_LIMIT_CONFIG);
        for (int i = 0; i < 16; i++) begin
            d = {i[1:0], 6'(1 << (i % 6)), i[3:0], i[3:0]};
            wr_reg(PLC_ADDR_PROT_LIMIT_CONFIG, d);
            rd_reg(PLC_ADDR_PROT_LIMIT_CONFIG);
        end
        for (int i = 0; i < 40; i++) begin
            addr_pick: begin
                logic [7:0] ad;
                ad = ($urandom % 4 == 0) ? 8'($urandom)
                                         : PLC_ADDR_PROT_LIMIT_CONFIG;
                wr_reg(ad, 16'($urandom));
                rd_reg(8'($urandom));
            end
        end
        wr_reg(PLC_ADDR_PROT_LIMIT_CONFIG, 16'hffff);
        d = mdl_q;
        host.access(1'b1, 1'b1, PLC_ADDR_PROT_LIMIT_CONFIG, 16'h5a5a,
                    a, h, got);
        mdl_q = 16'h5a5a;
        chk(got, d);
        chk(16'({a, h}), 16'h0003);
        check_all();
        do_reset();
        rd_reg(PLC_ADDR_PROT_LIMIT_CONFIG);
        give_verdict();
    end
endmodule
